// ### shared/bri_consts.vh
// Constants for the board interrupt routing block
`ifndef BRI_CONSTS_VH
`define BRI_CONSTS_VH

// ****************************************
// Line numbers
// ****************************************
`define BRI_NUM_LINES    16
`define BRI_CASCADE_LINE 2
`define BRI_SEC_FIRST    8
`define BRI_SPUR_LINE    4'h7
// Idle level of the synchronised pins: active-low lines high, the others low
`define BRI_SYNC_IDLE    20'h08fff

// ****************************************
// Levels, vectors and default map
// ****************************************
`define BRI_LEVEL_LOWEST 4'hf
`define BRI_VEC_BASE     8'h20
// Per-line level, line 15 in the top nibble, line 0 in the bottom
`define BRI_DEF_LEVELS   64'ha9876543fedcb021
// Identity mapping of source slots onto lines
`define BRI_DEF_LINE_SEL 64'hfedcba9876543210

// ****************************************
// Source slots of the default map
// ****************************************
`define BRI_SRC_TIMER    0
`define BRI_SRC_USER1    1
`define BRI_SRC_SER2     3
`define BRI_SRC_SER1     4
`define BRI_SRC_INTD     5
`define BRI_SRC_USER6    6
`define BRI_SRC_USER7    7
`define BRI_SRC_CIO      8
`define BRI_SRC_INTA     10
`define BRI_SRC_INTB     11
`define BRI_SRC_USER12   12
`define BRI_SRC_INTC     14

`endif

// ### logic/bri_top.v
// Board interrupt routing: source collection, cascaded controller and NMI path
`timescale 1ns/10ps
`include "bri_consts.vh"

// Overview of operation
// - Four PCI interrupt lines are separate sources
// - On-board ISA devices are distinct sources
// - VMEbus interface requests arrive on PCI INTB
// - Power-fail and system-fail may raise PCI request
// - Two cascaded controllers, thirteen external, three internal
// - Each line has its own enable
// - Vector supplied on acknowledge except NMI
// - Channel check drives machine check input
// - NMI outranks all, delivered without vector
// - Level zero highest, fifteen lowest
// - Source mapping and priority set by software
// - Mezzanine lines rotated differently per slot
module bri_top (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // PCI interrupt lines, active low
  input  wire [3:0]  board_pci_int_n,
  input  wire [3:0]  slot1_pci_int_n,
  input  wire [3:0]  slot2_pci_int_n,
  // ISA and board devices, active high except cio_irq_n, which is active low
  input  wire        timer_irq,
  input  wire        serial1_irq,
  input  wire        serial2_irq,
  input  wire        cio_irq_n,
  input  wire [3:0]  user_irq,
  // VMEbus bridge side
  input  wire        vme_irq,
  input  wire        vme_power_fail_n,
  input  wire        vme_sys_fail_n,
  input  wire        power_fail_route_en,
  input  wire        sys_fail_route_en,
  // Channel check request, active low
  input  wire        iochk_n,
  // Configuration
  input  wire [15:0] src_enable,
  input  wire [63:0] line_sel,
  input  wire [63:0] line_level,
  // Processor side
  input  wire        int_ack,
  input  wire        eoi,
  output wire        int_req,
  output reg  [7:0]  vector_out,
  output reg         vector_valid,
  output reg         machine_check_in_n
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam NSYNC = 20;

  wire [NSYNC-1:0] raw_in;
  reg  [NSYNC-1:0] sync_a;
  reg  [NSYNC-1:0] sync_b;

  assign raw_in = {user_irq, cio_irq_n, serial2_irq, serial1_irq, timer_irq,
                   slot2_pci_int_n, slot1_pci_int_n, board_pci_int_n};

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Idle levels, so no false request shows in the cycles after reset
      sync_a <= `BRI_SYNC_IDLE;
      sync_b <= `BRI_SYNC_IDLE;
    end
    else
    begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  wire [3:0] brd_n   = sync_b[3:0];
  wire [3:0] s1_n    = sync_b[7:4];
  wire [3:0] s2_n    = sync_b[11:8];
  wire       tmr     = sync_b[12];
  wire       ser1    = sync_b[13];
  wire       ser2    = sync_b[14];
  wire       cio     = ~sync_b[15];
  wire [3:0] usr     = sync_b[19:16];
  // VME and check pins take one stage more, matching the bridge hop
  reg        vme_s;
  reg        pf_s_n;
  reg        sf_s_n;
  reg        chk_s_n;
  reg        vme_irq_a;
  reg        vme_irq_q;
  reg        pf_a;
  reg        pf_q;
  reg        sf_a;
  reg        sf_q;
  reg        chk_a;
  reg        chk_q;

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vme_s   <= 1'b0;
      pf_s_n  <= 1'b1;
      sf_s_n  <= 1'b1;
      chk_s_n <= 1'b1;
    end
    else
    begin
      vme_s   <= vme_irq_q;
      pf_s_n  <= pf_q;
      sf_s_n  <= sf_q;
      chk_s_n <= chk_q;
    end
  end

  // First two stages of the VME and check pins

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vme_irq_a <= 1'b0;
      vme_irq_q <= 1'b0;
      pf_a      <= 1'b1;
      pf_q      <= 1'b1;
      sf_a      <= 1'b1;
      sf_q      <= 1'b1;
      chk_a     <= 1'b1;
      chk_q     <= 1'b1;
    end
    else
    begin
      vme_irq_a <= vme_irq;
      vme_irq_q <= vme_irq_a;
      pf_a      <= vme_power_fail_n;
      pf_q      <= pf_a;
      sf_a      <= vme_sys_fail_n;
      sf_q      <= sf_a;
      chk_a     <= iochk_n;
      chk_q     <= chk_a;
    end
  end

  // ****************************************
  // PCI line merge
  // ****************************************
  // Bridge input order is INTA..INTD in bits 0..3; lines are wired-OR low
  wire [3:0] pci_n;
  wire       vme_pull_n;

  assign vme_pull_n = ~vme_s & ~(power_fail_route_en & ~pf_s_n)
                      & ~(sys_fail_route_en & ~sf_s_n);
  assign pci_n[0] = brd_n[0] & s1_n[2] & s2_n[1];
  assign pci_n[1] = brd_n[1] & s1_n[3] & s2_n[2] & vme_pull_n;
  assign pci_n[2] = brd_n[2] & s1_n[0] & s2_n[3];
  assign pci_n[3] = brd_n[3] & s1_n[1] & s2_n[0];

  // ****************************************
  // Source slots and line mapping
  // ****************************************
  reg [15:0] src;

  always @*
  begin
    src = 16'h0000;
    src[`BRI_SRC_TIMER]  = tmr;
    src[`BRI_SRC_USER1]  = usr[0];
    src[`BRI_SRC_SER2]   = ser2;
    src[`BRI_SRC_SER1]   = ser1;
    src[`BRI_SRC_INTD]   = ~pci_n[3];
    src[`BRI_SRC_USER6]  = usr[1];
    src[`BRI_SRC_USER7]  = usr[2];
    src[`BRI_SRC_CIO]    = cio;
    src[`BRI_SRC_INTA]   = ~pci_n[0];
    src[`BRI_SRC_INTB]   = ~pci_n[1];
    src[`BRI_SRC_USER12] = usr[3];
    src[`BRI_SRC_INTC]   = ~pci_n[2];
  end

  reg  [15:0] isr;
  wire [15:0] line_raw;
  wire [15:0] line_req;
  wire        sec_req;

  genvar gi;
  generate
    for (gi = 0; gi < `BRI_NUM_LINES; gi = gi + 1)
    begin : g_line
      // Any source slot may be steered onto any line
      assign line_raw[gi] = src[line_sel[4*gi +: 4]] & src_enable[gi];
    end
  endgenerate

  // Secondary lines reach the processor only through the cascade input
  assign sec_req  = |(line_raw[15:8] & ~isr[15:8]);
  assign line_req = {line_raw[15:8], line_raw[7:3], sec_req, line_raw[1:0]};

  // ****************************************
  // Arbitration
  // ****************************************
  // Returns {found, level, line} of the lowest level number in mask
  function [8:0] pick;
    input [15:0] mask;
    input [63:0] lv;
    integer      k;
    reg   [3:0]  bl;
    reg   [3:0]  bn;
    reg          f;
    begin
      bl = `BRI_LEVEL_LOWEST;
      bn = 4'h0;
      f  = 1'b0;
      for (k = 0; k < `BRI_NUM_LINES; k = k + 1)
      begin
        if (mask[k] && (!f || lv[4*k +: 4] < bl))
        begin
          f  = 1'b1;
          bl = lv[4*k +: 4];
          bn = k[3:0];
        end
      end
      pick = {f, bl, bn};
    end
  endfunction

  wire [15:0] req_flat;
  wire [8:0]  win;
  wire [8:0]  cur;
  wire        can_int;

  // Cascade line itself is never a target; its secondary lines compete directly
  assign req_flat = {line_raw[15:8], line_raw[7:3], 1'b0, line_raw[1:0]}
                    & {{8{line_req[`BRI_CASCADE_LINE]}}, 8'hff} & ~isr;
  assign win      = pick(req_flat, line_level);
  assign cur      = pick(isr, line_level);
  assign can_int  = win[8] && (!cur[8] || win[7:4] < cur[7:4]);
  // NMI outranks every vectored request, until its output is released as well
  assign int_req  = can_int & chk_s_n & machine_check_in_n;

  // ****************************************
  // Acknowledge and end of interrupt
  // ****************************************
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      isr                <= 16'h0000;
      vector_out         <= 8'h00;
      vector_valid       <= 1'b0;
      machine_check_in_n <= 1'b1;
    end
    else
    begin
      machine_check_in_n <= chk_s_n;
      vector_valid       <= int_ack;
      if (int_ack)
      begin
        if (can_int)
          vector_out <= `BRI_VEC_BASE + {4'h0, win[3:0]};
        else
          vector_out <= `BRI_VEC_BASE + {4'h0, `BRI_SPUR_LINE};
      end
      // Acknowledge set wins over an end-of-interrupt in the same cycle
      isr <= (isr & ~((eoi && cur[8]) ? (16'h0001 << cur[3:0]) : 16'h0000))
             | ((int_ack && can_int) ? (16'h0001 << win[3:0]) : 16'h0000);
    end
  end

endmodule

// ### bench/bri_top_assertions.sv
// Checker for the board interrupt routing ports
`timescale 1ns/10ps
module bri_checker (
  // Clock and reset
  input wire        core_clk,
  input wire        rst_n,
  // Watched ports
  input wire        iochk_n,
  input wire [15:0] src_enable,
  input wire        int_ack,
  input wire        int_req,
  input wire [7:0]  vector_out,
  input wire        vector_valid,
  input wire        machine_check_in_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Six samples cover the synchroniser delay with margin
  sequence s_chk_on;
    !iochk_n [*6];
  endsequence
  sequence s_chk_off;
    iochk_n [*6];
  endsequence
  a_ack_answer: assert property (int_ack |=> vector_valid)
    else $error("no vector after ack");
  a_valid_cause: assert property (vector_valid |-> $past(int_ack))
    else $error("vector without ack");
  a_vector_holds: assert property (!vector_valid |-> $stable(vector_out))
    else $error("vector moved without ack");
  a_vector_range: assert property (vector_valid |-> vector_out[7:4] == 4'h2)
    else $error("vector outside sixteen lines");
  a_cascade_free: assert property (vector_valid |-> vector_out != 8'h22)
    else $error("cascade line delivered");
  a_nmi_silent: assert property (!machine_check_in_n |-> !int_req)
    else $error("vectored request during nmi");
  a_nmi_assert: assert property (s_chk_on |-> !machine_check_in_n)
    else $error("channel check not forwarded");
  a_nmi_release: assert property (s_chk_off |-> machine_check_in_n)
    else $error("nmi without channel check");
  a_disabled_quiet: assert property ((src_enable == 16'h0000) [*4] |-> !int_req)
    else $error("request with all sources off");
endmodule

bind bri_top bri_checker u_chk (.core_clk, .rst_n, .iochk_n, .src_enable, .int_ack,
  .int_req, .vector_out, .vector_valid, .machine_check_in_n);

// ### bench/bri_cpu_model.sv
// Processor core model: acknowledges vectored requests and ends service
`timescale 1ns/10ps
module bri_cpu_model (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rst_n,
  // Controller side
  input  wire       int_req,
  input  wire [7:0] vector_out,
  input  wire       vector_valid,
  output reg        int_ack,
  output reg        eoi,
  // Bench control
  input  wire [3:0] stall,
  output reg  [7:0] last_vec,
  output reg  [7:0] got
);
  reg [3:0] wait_cnt;
  reg       busy;
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_ack  <= 1'b0;
      eoi      <= 1'b0;
      busy     <= 1'b0;
      wait_cnt <= 4'h0;
      got      <= 8'h00;
      last_vec <= 8'h00;
    end
    else
    begin
      int_ack <= !vector_valid && int_req && !busy && (wait_cnt >= stall);
      eoi     <= vector_valid;
      if (vector_valid)
      begin
        // The vector is taken in its one valid cycle
        last_vec <= vector_out;
        got      <= got + 8'h01;
        busy     <= 1'b0;
      end
      else if (int_req && !busy)
      begin
        // A stall lets competing requests line up before the ack
        if (wait_cnt >= stall)
        begin
          busy     <= 1'b1;
          wait_cnt <= 4'h0;
        end
        else
          wait_cnt <= wait_cnt + 4'h1;
      end
      else if (!int_req)
        // A withdrawn request leaves no partial stall behind
        wait_cnt <= 4'h0;
    end
  end
endmodule

// ### bench/board_interrupt_routing_bench.sv
// Self-checking bench for the board interrupt routing block
`timescale 1ns/10ps
`include "bri_consts.vh"
module board_interrupt_routing_bench;
  logic        core_clk = 1'b0, rst_n = 1'b0, iochk_n = 1'b1;
  logic        timer_irq = 1'b0, serial1_irq = 1'b0, serial2_irq = 1'b0, cio_irq_n = 1'b1;
  logic [3:0]  board_pci_int_n = 4'hf, slot1_pci_int_n = 4'hf, slot2_pci_int_n = 4'hf;
  logic [3:0]  user_irq = 4'h0, stall = 4'h0;
  logic        vme_irq = 1'b0, vme_power_fail_n = 1'b1, vme_sys_fail_n = 1'b1;
  logic        power_fail_route_en = 1'b0, sys_fail_route_en = 1'b0;
  logic [15:0] src_enable = 16'hffff;
  logic [63:0] line_sel = `BRI_DEF_LINE_SEL, line_level = `BRI_DEF_LEVELS;
  wire         int_ack, eoi, int_req, vector_valid, machine_check_in_n;
  wire  [7:0]  vector_out, last_vec, got;
  int          failures = 0, n_tests = 0, cycles = 0;
  logic [7:0]  vec_tab [0:22] = '{8'h20, 8'h24, 8'h23, 8'h28, 8'h21, 8'h26, 8'h27, 8'h2c,
    8'h2a, 8'h2b, 8'h2e, 8'h25, 8'h2e, 8'h25, 8'h2a, 8'h2b, 8'h25, 8'h2a, 8'h2b, 8'h2e,
    8'h2b, 8'h2b, 8'h2b};

  bri_top dut (.core_clk, .rst_n, .board_pci_int_n, .slot1_pci_int_n, .slot2_pci_int_n,
    .timer_irq, .serial1_irq, .serial2_irq, .cio_irq_n, .user_irq, .vme_irq,
    .vme_power_fail_n, .vme_sys_fail_n, .power_fail_route_en, .sys_fail_route_en,
    .iochk_n, .src_enable, .line_sel, .line_level, .int_ack, .eoi, .int_req,
    .vector_out, .vector_valid, .machine_check_in_n);
  bri_cpu_model cpu (.core_clk, .rst_n, .int_req, .vector_out, .vector_valid, .int_ack,
    .eoi, .stall, .last_vec, .got);

  initial
  begin
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic conclude;
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic settle;
    repeat (12) @(negedge core_clk);
  endtask

  task automatic drive(input int s, input logic on);
    @(posedge core_clk);
    if (s == 0) timer_irq <= on;
    else if (s == 1) serial1_irq <= on;
    else if (s == 2) serial2_irq <= on;
    else if (s == 3) cio_irq_n <= !on;
    else if (s < 8) user_irq[s-4] <= on;
    else if (s < 12) board_pci_int_n[s-8] <= !on;
    else if (s < 16) slot1_pci_int_n[s-12] <= !on;
    else if (s < 20) slot2_pci_int_n[s-16] <= !on;
    else if (s == 20) vme_irq <= on;
    else if (s == 21) vme_power_fail_n <= !on;
    else if (s == 22) vme_sys_fail_n <= !on;
    else iochk_n <= !on;
  endtask

  // A missing vector shows as unknown so it can never match
  task automatic expect_vec(input logic [7:0] exp, input logic [7:0] g0);
    for (int k = 0; k < 200 && got === g0; k++)
      @(negedge core_clk);
    check("vector", (got === g0) ? 8'hxx : last_vec, exp);
  endtask

  task automatic t_routes;
    for (int s = 21; s < 23; s++)
    begin
      drive(s, 1'b1);
      settle;
      check("unrouted fail", {7'h00, int_req}, 8'h00);
      drive(s, 1'b0);
      settle;
    end
  endtask

  task automatic t_sources;
    logic [7:0] g0;
    @(posedge core_clk);
    power_fail_route_en <= 1'b1;
    sys_fail_route_en   <= 1'b1;
    for (int s = 0; s < 23; s++)
    begin
      g0 = got;
      drive(s, 1'b1);
      expect_vec(vec_tab[s], g0);
      drive(s, 1'b0);
      settle;
    end
  endtask

  task automatic t_priority;
    logic [7:0] g0;
    @(posedge core_clk);
    stall <= 4'h8;
    g0 = got;
    drive(1, 1'b1);
    drive(3, 1'b1);
    expect_vec(8'h28, g0);
    g0 = got;
    drive(3, 1'b0);
    expect_vec(8'h24, g0);
    drive(1, 1'b0);
    settle;
  endtask

  task automatic t_remap;
    logic [7:0] g0;
    @(posedge core_clk);
    line_level[19:16] <= 4'h0;
    g0 = got;
    drive(0, 1'b1);
    drive(1, 1'b1);
    expect_vec(8'h24, g0);
    g0 = got;
    drive(1, 1'b0);
    expect_vec(8'h20, g0);
    drive(0, 1'b0);
    settle;
    @(posedge core_clk);
    line_sel[39:36] <= 4'h4;
    src_enable[4]   <= 1'b0;
    g0 = got;
    drive(1, 1'b1);
    expect_vec(8'h29, g0);
    drive(1, 1'b0);
    settle;
    @(posedge core_clk);
    line_sel   <= `BRI_DEF_LINE_SEL;
    line_level <= `BRI_DEF_LEVELS;
  endtask

  task automatic t_enable;
    logic [7:0] g0;
    @(posedge core_clk);
    src_enable <= 16'h0000;
    g0 = got;
    drive(1, 1'b1);
    settle;
    check("disabled request", {7'h00, int_req}, 8'h00);
    @(posedge core_clk);
    src_enable <= 16'hffff;
    expect_vec(8'h24, g0);
    drive(1, 1'b0);
    settle;
  endtask

  task automatic t_nmi;
    logic [7:0] g0;
    g0 = got;
    drive(23, 1'b1);
    drive(1, 1'b1);
    settle;
    check("nmi out", {7'h00, machine_check_in_n}, 8'h00);
    check("vectored during nmi", {7'h00, int_req}, 8'h00);
    check("no vector during nmi", got, g0);
    drive(23, 1'b0);
    expect_vec(8'h24, g0);
    check("nmi released", {7'h00, machine_check_in_n}, 8'h01);
    drive(1, 1'b0);
    settle;
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      failures++;
      conclude;
    end
  end

  initial
  begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    settle;
    t_routes;
    t_sources;
    t_priority;
    t_remap;
    t_enable;
    t_nmi;
    conclude;
  end
endmodule
